// >>> design/pmsd_top.sv
// module: program memory space decoder with config latch and register port
`default_nettype none
module pmsd_top #(
  parameter int FLASH_KBYTES = pmsd_pkg::FLASH_KB_SMALL,
  parameter bit HAS_EXT_BUS  = 1'b1,
  parameter int DATA_ADDR_W  = 12
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_in,
  input  wire logic [7:0]             cfg_byte_in,
  input  wire logic [3:0]             reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic      [7:0]             reg_rdata_out,
  input  wire logic                   fetch_req_in,
  input  wire pmsd_pkg::pmsd_req_t    fetch_in,
  input  wire logic                   flash_rvalid_in,
  input  wire logic [15:0]            flash_rdata_in,
  input  wire logic                   ext_rvalid_in,
  input  wire logic [15:0]            ext_rdata_in,
  input  wire logic                   data_req_in,
  input  wire logic                   data_we_in,
  input  wire logic [DATA_ADDR_W-1:0] data_addr_in,
  output logic                        flash_req_out,
  output logic                        ext_req_out,
  output logic                        prog_we_out,
  output logic      [20:0]            prog_addr_out,
  output logic                        blocked_out,
  output logic                        prog_word_valid_out,
  output logic      [15:0]            prog_word_out,
  output logic      [1:0]             ext_wait_out,
  output logic      [1:0]             memory_map_select_out,
  output logic                        data_req_out,
  output logic                        data_we_out,
  output logic      [DATA_ADDR_W-1:0] data_addr_out
);
  // flash size picks both limits; boot block is larger only on the smallest part
  localparam logic [20:0] FLASH_TOP =
    (FLASH_KBYTES == pmsd_pkg::FLASH_KB_SMALL) ? pmsd_pkg::FLASH_TOP_32K :
    (FLASH_KBYTES == pmsd_pkg::FLASH_KB_MID)   ? pmsd_pkg::FLASH_TOP_64K :
                                                 pmsd_pkg::FLASH_TOP_128K;
  localparam logic [20:0] BOOT_TOP =
    (FLASH_KBYTES == pmsd_pkg::FLASH_KB_SMALL) ? pmsd_pkg::BOOT_TOP_SMALL :
                                                 pmsd_pkg::BOOT_TOP_LARGE;

  pmsd_pkg::pmsd_state_t state;
  pmsd_pkg::pmsd_state_t next_state;
  pmsd_pkg::pmsd_map_t   mode;
  pmsd_pkg::pmsd_route_t route;
  logic [7:0]            cfg_meta;
  logic [7:0]            cfg_sync;
  logic [7:0]            cfg_img;
  logic                  wait_dis;
  logic [1:0]            wait_count;
  logic                  blocked_seen;

  wire pmsd_pkg::pmsd_map_t next_mode;
  wire logic                taken;
  wire logic                wr_memcon;
  wire logic                wr_status;
  wire logic                block_set;
  wire logic                block_clr;
  wire logic [7:0]          memcon_img;
  wire logic [7:0]          status_img;
  wire logic [7:0]          next_rdata;
  wire logic [15:0]         next_word;
  wire logic                next_valid;

  // fuse pins are not of this clock; two stages before anything reads them
  always_ff @(posedge clk_sys_in) begin
    cfg_meta <= cfg_byte_in;
    cfg_sync <= cfg_meta;
  end

  always_comb begin
    case (state)
      pmsd_pkg::st_hold: next_state = pmsd_pkg::st_run;
      pmsd_pkg::st_run:  next_state = pmsd_pkg::st_run;
      default:           next_state = pmsd_pkg::st_hold;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= pmsd_pkg::st_hold;
    end else begin
      state <= next_state;
    end
  end

  assign next_mode = HAS_EXT_BUS ?
    pmsd_pkg::pmsd_map_t'(cfg_sync[pmsd_pkg::CFG_MODE_LSB +: 2]) :
    pmsd_pkg::internal_only_map;

  // map is caught once, on the first edge after release, so it never moves mid-run
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mode     <= pmsd_pkg::internal_only_map;
      wait_dis <= 1'b1;
      cfg_img  <= pmsd_pkg::CFG_ERASED;
    end else if (state == pmsd_pkg::st_hold) begin
      mode     <= next_mode;
      wait_dis <= cfg_sync[pmsd_pkg::CFG_WAIT_BIT];
      cfg_img  <= {cfg_sync[pmsd_pkg::CFG_WAIT_BIT], 5'h00, cfg_sync[1:0]};
    end
  end

  pmsd_map_decode #(
    .FLASH_TOP (FLASH_TOP),
    .BOOT_TOP  (BOOT_TOP)
  ) u_decode (
    .mode_in   (mode),
    .req_in    (fetch_in),
    .route_out (route)
  );

  // requests during the latch cycle are dropped; the map is not valid yet
  assign taken = fetch_req_in & (state == pmsd_pkg::st_run);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      flash_req_out <= 1'b0;
      ext_req_out   <= 1'b0;
      prog_we_out   <= 1'b0;
      blocked_out   <= 1'b0;
      prog_addr_out <= pmsd_pkg::VEC_RESET_ADDR;
    end else begin
      flash_req_out <= taken & route.flash;
      ext_req_out   <= taken & route.ext;
      prog_we_out   <= taken & route.we & (route.flash | route.ext);
      blocked_out   <= taken & route.blocked;
      prog_addr_out <= taken ? route.addr : prog_addr_out;
    end
  end

  // one fetch outstanding at a time, so a zero fill never meets a memory return
  assign next_valid = (taken & route.zero) | flash_rvalid_in | ext_rvalid_in;
  assign next_word  = (taken & route.zero) ? pmsd_pkg::NOP_WORD :
                      flash_rvalid_in      ? flash_rdata_in :
                      ext_rvalid_in        ? ext_rdata_in : pmsd_pkg::NOP_WORD;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prog_word_valid_out <= 1'b0;
      prog_word_out       <= pmsd_pkg::NOP_WORD;
    end else begin
      prog_word_valid_out <= next_valid;
      prog_word_out       <= next_word;
    end
  end

  // data side has its own bus, untouched by the program map
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      data_req_out  <= 1'b0;
      data_we_out   <= 1'b0;
      data_addr_out <= '0;
    end else begin
      data_req_out  <= data_req_in;
      data_we_out   <= data_req_in & data_we_in;
      data_addr_out <= data_req_in ? data_addr_in : data_addr_out;
    end
  end

  assign wr_memcon  = reg_wr_in & (reg_addr_in == pmsd_pkg::REG_MEMCON);
  assign wr_status  = reg_wr_in & (reg_addr_in == pmsd_pkg::REG_STATUS);
  assign block_set  = taken & route.blocked;
  assign block_clr  = wr_status & reg_wdata_in[pmsd_pkg::STAT_BLOCK_BIT];
  assign memcon_img = {2'b00, wait_count, 4'h0};
  assign status_img = {blocked_seen, HAS_EXT_BUS, state == pmsd_pkg::st_run, 3'b000, mode};
  assign next_rdata = (reg_addr_in == pmsd_pkg::REG_CFG)    ? cfg_img :
                      (reg_addr_in == pmsd_pkg::REG_MEMCON) ? memcon_img :
                      (reg_addr_in == pmsd_pkg::REG_STATUS) ? status_img : 8'h00;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wait_count   <= pmsd_pkg::MEMCON_WAIT_RST;
      blocked_seen <= 1'b0;
      reg_rdata_out <= 8'h00;
    end else begin
      wait_count   <= wr_memcon ? reg_wdata_in[pmsd_pkg::MEMCON_WAIT_LSB +: 2] : wait_count;
      // a new block event beats a clear in the same cycle
      blocked_seen <= block_set | (blocked_seen & ~block_clr);
      reg_rdata_out <= reg_rd_in ? next_rdata : 8'h00;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ext_wait_out          <= 2'b00;
      memory_map_select_out <= pmsd_pkg::internal_only_map;
    end else begin
      ext_wait_out          <= wait_dis ? 2'b00 : wait_count;
      memory_map_select_out <= mode;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_ext_only_route: assert property (
    taken && mode == pmsd_pkg::external_only_map |=> ext_req_out && !flash_req_out
  ) else $error("external-only access not sent outside");

  a_boot_low_flash: assert property (
    taken && mode == pmsd_pkg::boot_block_map && route.addr <= BOOT_TOP
    |=> flash_req_out && !ext_req_out
  ) else $error("boot block access not sent to flash");

  a_boot_high_ext: assert property (
    taken && mode == pmsd_pkg::boot_block_map && route.addr > BOOT_TOP
    |=> ext_req_out && !flash_req_out
  ) else $error("access above boot block not sent outside");

  a_emc_split: assert property (
    taken && mode == pmsd_pkg::extended_map
    |=> (flash_req_out == ($past(route.addr) <= FLASH_TOP)) && (ext_req_out != flash_req_out)
  ) else $error("extended map split at wrong address");

  a_int_zero_fill: assert property (
    taken && mode == pmsd_pkg::internal_only_map && route.addr > FLASH_TOP
    && fetch_in.kind != pmsd_pkg::kind_twrite && !flash_rvalid_in && !ext_rvalid_in
    |=> prog_word_valid_out && prog_word_out == pmsd_pkg::NOP_WORD && !flash_req_out
  ) else $error("read above flash limit not zero filled");

  a_no_cross_access: assert property (
    state == pmsd_pkg::st_run |=>
    !(ext_req_out && $past(mode) == pmsd_pkg::internal_only_map) &&
    !(flash_req_out && $past(mode) == pmsd_pkg::external_only_map)
  ) else $error("access reached a memory the mode excludes");

  a_vector_high: assert property (
    taken && fetch_in.vec == pmsd_pkg::vec_high |=> prog_addr_out == pmsd_pkg::VEC_HIGH_ADDR
  ) else $error("high interrupt vector address wrong");

  a_mode_frozen: assert property (
    state == pmsd_pkg::st_run |=> $stable(mode) [*8]
  ) else $error("memory map changed while running");

  a_no_bus_internal: assert property (
    !HAS_EXT_BUS && state == pmsd_pkg::st_run |-> mode == pmsd_pkg::internal_only_map
  ) else $error("variant without bus left internal-only mode");

  a_wait_gate: assert property (
    state == pmsd_pkg::st_run ##1 1'b1 |-> ext_wait_out == ($past(wait_dis) ? 2'b00 : $past(wait_count))
  ) else $error("wait field not gated by wait enable");

  a_cfg_unimpl_zero: assert property (
    reg_rd_in && reg_addr_in == pmsd_pkg::REG_CFG |=> reg_rdata_out[6:2] == 5'h00
  ) else $error("unimplemented config bits read nonzero");

  a_data_free: assert property (
    data_req_in |=> data_req_out && data_addr_out == $past(data_addr_in)
  ) else $error("data access gated by program map");

  a_blocked_write: assert property (
    taken && route.blocked
    |=> blocked_out && !flash_req_out && !ext_req_out
  ) else $error("blocked table write reached a memory");

  a_vector_reset: assert property (
    taken && fetch_in.vec == pmsd_pkg::vec_reset
    |=> prog_addr_out == pmsd_pkg::VEC_RESET_ADDR
  ) else $error("reset vector address wrong");

  a_vector_low: assert property (
    taken && fetch_in.vec == pmsd_pkg::vec_low
    |=> prog_addr_out == pmsd_pkg::VEC_LOW_ADDR
  ) else $error("low interrupt vector address wrong");

  a_erased_reset: assert property (
    $past(rst_in) && !rst_in
    |-> memory_map_select_out == pmsd_pkg::internal_only_map && ext_wait_out == 2'b00
  ) else $error("outputs not at erased defaults after reset");

  a_ext_no_fill: assert property (
    taken && mode == pmsd_pkg::external_only_map && !flash_rvalid_in && !ext_rvalid_in
    |=> !prog_word_valid_out
  ) else $error("external-only access zero filled");

  a_word_return: assert property (
    flash_rvalid_in && !(taken && route.zero)
    |=> prog_word_valid_out && prog_word_out == $past(flash_rdata_in)
  ) else $error("flash word not passed through");

  c_boot_switch: cover property (
    taken && mode == pmsd_pkg::boot_block_map ##1 taken && route.ext);
  c_zero_fill: cover property (taken && route.zero ##1 prog_word_valid_out);
  c_blocked_write: cover property (taken && route.blocked ##1 blocked_out);
  c_fetch_and_data: cover property (flash_req_out && data_req_out);
  c_wait_on: cover property (ext_wait_out != 2'b00);
endmodule : pmsd_top
`default_nettype wire

// >>> design/pmsd_pkg.sv
// package: constants and types of the program memory space decoder
`default_nettype none
package pmsd_pkg;
  localparam int          ADDR_W          = 21;
  localparam int          WORD_W          = 16;
  localparam int          CFG_W           = 8;
  localparam logic [20:0] VEC_RESET_ADDR  = 21'h000000;
  localparam logic [20:0] VEC_HIGH_ADDR   = 21'h000008;
  localparam logic [20:0] VEC_LOW_ADDR    = 21'h000018;
  localparam int          FLASH_KB_SMALL  = 32;
  localparam int          FLASH_KB_MID    = 64;
  localparam int          FLASH_KB_LARGE  = 128;
  localparam logic [20:0] FLASH_TOP_32K   = 21'h007fff;
  localparam logic [20:0] FLASH_TOP_64K   = 21'h00ffff;
  localparam logic [20:0] FLASH_TOP_128K  = 21'h01ffff;
  localparam logic [20:0] BOOT_TOP_SMALL  = 21'h0007ff;
  localparam logic [20:0] BOOT_TOP_LARGE  = 21'h0001ff;
  localparam logic [15:0] NOP_WORD        = 16'h0000;
  // configuration byte layout
  localparam int          CFG_WAIT_BIT    = 7;
  localparam int          CFG_MODE_LSB    = 0;
  localparam logic [7:0]  CFG_ERASED      = 8'h83;
  // register port
  localparam logic [3:0]  REG_CFG         = 4'h0;
  localparam logic [3:0]  REG_MEMCON      = 4'h1;
  localparam logic [3:0]  REG_STATUS      = 4'h2;
  localparam int          MEMCON_WAIT_LSB = 4;
  localparam logic [1:0]  MEMCON_WAIT_RST = 2'h0;
  localparam int          STAT_BLOCK_BIT  = 7;
  localparam int          STAT_EXT_BIT    = 6;
  localparam int          STAT_RUN_BIT    = 5;

  typedef enum logic [1:0] {
    extended_map      = 2'b00,
    boot_block_map    = 2'b01,
    external_only_map = 2'b10,
    internal_only_map = 2'b11
  } pmsd_map_t;

  typedef enum logic [1:0] {
    kind_exec   = 2'b00,
    kind_tread  = 2'b01,
    kind_twrite = 2'b10
  } pmsd_kind_t;

  typedef enum logic [1:0] {
    vec_none  = 2'b00,
    vec_reset = 2'b01,
    vec_high  = 2'b10,
    vec_low   = 2'b11
  } pmsd_vec_t;

  typedef enum logic {
    st_hold = 1'b0,
    st_run  = 1'b1
  } pmsd_state_t;

  typedef struct packed {
    pmsd_vec_t   vec;
    pmsd_kind_t  kind;
    logic [20:0] addr;
  } pmsd_req_t;

  typedef struct packed {
    logic        flash;
    logic        ext;
    logic        zero;
    logic        blocked;
    logic        we;
    logic [20:0] addr;
  } pmsd_route_t;
endpackage : pmsd_pkg
`default_nettype wire

// >>> design/pmsd_map_decode.sv
// module: address-to-memory routing of one program access
`default_nettype none
module pmsd_map_decode #(
  parameter logic [20:0] FLASH_TOP = pmsd_pkg::FLASH_TOP_32K,
  parameter logic [20:0] BOOT_TOP  = pmsd_pkg::BOOT_TOP_SMALL
) (
  input  wire pmsd_pkg::pmsd_map_t   mode_in,
  input  wire pmsd_pkg::pmsd_req_t   req_in,
  output wire pmsd_pkg::pmsd_route_t route_out
);
  function automatic logic at_or_below(input logic [20:0] a, input logic [20:0] top);
    at_or_below = (a <= top);
  endfunction : at_or_below

  function automatic logic [20:0] vec_addr(input pmsd_pkg::pmsd_vec_t v, input logic [20:0] a);
    case (v)
      pmsd_pkg::vec_reset: vec_addr = pmsd_pkg::VEC_RESET_ADDR;
      pmsd_pkg::vec_high:  vec_addr = pmsd_pkg::VEC_HIGH_ADDR;
      pmsd_pkg::vec_low:   vec_addr = pmsd_pkg::VEC_LOW_ADDR;
      default:             vec_addr = a;
    endcase
  endfunction : vec_addr

  wire logic [20:0] addr;
  wire logic        in_flash;
  wire logic        in_boot;
  wire logic        m_ext;
  wire logic        m_boot;
  wire logic        m_int;
  wire logic        m_emc;
  wire logic        use_flash;
  wire logic        use_ext;
  wire logic        is_wr;

  assign addr      = vec_addr(req_in.vec, req_in.addr);
  assign in_flash  = at_or_below(addr, FLASH_TOP);
  assign in_boot   = at_or_below(addr, BOOT_TOP);
  assign m_ext     = (mode_in == pmsd_pkg::external_only_map);
  assign m_boot    = (mode_in == pmsd_pkg::boot_block_map);
  assign m_int     = (mode_in == pmsd_pkg::internal_only_map);
  assign m_emc     = (mode_in == pmsd_pkg::extended_map);
  // boundary switching is pure address compare, software never steps in
  assign use_flash = (m_boot & in_boot) | ((m_int | m_emc) & in_flash);
  assign use_ext   = m_ext | (m_boot & ~in_boot) | (m_emc & ~in_flash);
  assign is_wr     = (req_in.kind == pmsd_pkg::kind_twrite);

  assign route_out.flash   = use_flash;
  assign route_out.ext     = use_ext;
  assign route_out.zero    = ~use_flash & ~use_ext & ~is_wr;
  assign route_out.blocked = ~use_flash & ~use_ext & is_wr;
  assign route_out.we      = is_wr;
  assign route_out.addr    = addr;
endmodule : pmsd_map_decode
`default_nettype wire

// >>> verification/pmsd_mem_model.sv
// partner model: on-chip flash array and external program memory bus
`default_nettype none
module pmsd_mem_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        slow_in,
  input  wire logic        flash_req_in,
  input  wire logic        ext_req_in,
  input  wire logic        we_in,
  input  wire logic [20:0] addr_in,
  output logic             flash_rvalid_out,
  output logic [15:0]      flash_rdata_out,
  output logic             ext_rvalid_out,
  output logic [15:0]      ext_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  wait_cnt;
  logic        pend_ext;
  logic [20:0] pend_addr;
  always @(posedge clk_sys_in) begin
    flash_rvalid_out <= 1'b0;
    ext_rvalid_out   <= 1'b0;
    // idle data lines toggle so a stale word never passes for a fresh one
    flash_rdata_out  <= ~flash_rdata_out;
    ext_rdata_out    <= ~ext_rdata_out;
    if (rst_in) begin
      wait_cnt        <= 2'h0;
      flash_rdata_out <= 16'h0000;
      ext_rdata_out   <= 16'h0000;
    end else if ((flash_req_in || ext_req_in) && !we_in && slow_in) begin
      wait_cnt  <= 2'h3;
      pend_ext  <= ext_req_in;
      pend_addr <= addr_in;
    end else if (flash_req_in && !we_in) begin
      flash_rvalid_out <= 1'b1;
      flash_rdata_out  <= addr_in[15:0] ^ 16'h5a5a;
    end else if (ext_req_in && !we_in) begin
      ext_rvalid_out <= 1'b1;
      ext_rdata_out  <= addr_in[15:0] ^ 16'ha5a5;
    end else if (wait_cnt != 2'h0) begin
      wait_cnt <= wait_cnt - 2'h1;
      if (wait_cnt == 2'h1 && pend_ext) begin
        ext_rvalid_out <= 1'b1;
        ext_rdata_out  <= pend_addr[15:0] ^ 16'ha5a5;
      end else if (wait_cnt == 2'h1) begin
        flash_rvalid_out <= 1'b1;
        flash_rdata_out  <= pend_addr[15:0] ^ 16'h5a5a;
      end
    end
  end
endmodule : pmsd_mem_model
`default_nettype wire

// >>> verification/program_memory_space_decoder_tb.sv
// testbench: program memory space decoder against a flash and external bus model
`default_nettype none
module program_memory_space_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] F = 2'h0;
  localparam logic [1:0] E = 2'h1;
  localparam logic [1:0] Z = 2'h2;
  localparam logic [1:0] B = 2'h3;
  localparam pmsd_pkg::pmsd_kind_t EX = pmsd_pkg::kind_exec;
  localparam pmsd_pkg::pmsd_kind_t TR = pmsd_pkg::kind_tread;
  localparam pmsd_pkg::pmsd_kind_t TW = pmsd_pkg::kind_twrite;
  logic clk_sys_in = 1'b0;
  logic rst_in, reg_wr_in, reg_rd_in, fetch_req_in, data_req_in, data_we_in, slow;
  logic [7:0] cfg_byte_in, reg_wdata_in, reg_rdata_out;
  logic [3:0] reg_addr_in;
  pmsd_pkg::pmsd_req_t fetch_in;
  logic flash_rvalid_in, ext_rvalid_in, flash_req_out, ext_req_out, prog_we_out, blocked_out;
  logic [15:0] flash_rdata_in, ext_rdata_in, prog_word_out;
  logic [20:0] prog_addr_out;
  logic prog_word_valid_out, data_req_out, data_we_out;
  logic [1:0] ext_wait_out, memory_map_select_out;
  logic [11:0] data_addr_in, data_addr_out;
  int num_errors = 0;
  int cmp_count = 0;
  always #4 clk_sys_in = ~clk_sys_in;
  pmsd_top #(.FLASH_KBYTES(32), .HAS_EXT_BUS(1'b1), .DATA_ADDR_W(12)) DUT (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cfg_byte_in(cfg_byte_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .fetch_req_in(fetch_req_in), .fetch_in(fetch_in), .flash_rvalid_in(flash_rvalid_in),
    .flash_rdata_in(flash_rdata_in), .ext_rvalid_in(ext_rvalid_in), .ext_rdata_in(ext_rdata_in),
    .data_req_in(data_req_in), .data_we_in(data_we_in), .data_addr_in(data_addr_in),
    .flash_req_out(flash_req_out), .ext_req_out(ext_req_out), .prog_we_out(prog_we_out),
    .prog_addr_out(prog_addr_out), .blocked_out(blocked_out), .prog_word_valid_out(prog_word_valid_out),
    .prog_word_out(prog_word_out), .ext_wait_out(ext_wait_out), .memory_map_select_out(memory_map_select_out),
    .data_req_out(data_req_out), .data_we_out(data_we_out), .data_addr_out(data_addr_out));
  logic [1:0] nb_map;
  // same stimulus into a part without the outside bus; only its map is judged
  pmsd_top #(.FLASH_KBYTES(32), .HAS_EXT_BUS(1'b0), .DATA_ADDR_W(12)) DUT_NOBUS (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cfg_byte_in(cfg_byte_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(),
    .fetch_req_in(fetch_req_in), .fetch_in(fetch_in), .flash_rvalid_in(flash_rvalid_in),
    .flash_rdata_in(flash_rdata_in), .ext_rvalid_in(ext_rvalid_in), .ext_rdata_in(ext_rdata_in),
    .data_req_in(data_req_in), .data_we_in(data_we_in), .data_addr_in(data_addr_in),
    .flash_req_out(), .ext_req_out(), .prog_we_out(), .prog_addr_out(), .blocked_out(),
    .prog_word_valid_out(), .prog_word_out(), .ext_wait_out(), .memory_map_select_out(nb_map),
    .data_req_out(), .data_we_out(), .data_addr_out());
  pmsd_mem_model MEM (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .slow_in(slow), .flash_req_in(flash_req_out),
    .ext_req_in(ext_req_out), .we_in(prog_we_out), .addr_in(prog_addr_out),
    .flash_rvalid_out(flash_rvalid_in), .flash_rdata_out(flash_rdata_in),
    .ext_rvalid_out(ext_rvalid_in), .ext_rdata_out(ext_rdata_in));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset(input logic [7:0] c);
    @(posedge clk_sys_in);
    cfg_byte_in <= c;
    rst_in      <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    // step off the edge so outputs launched there have settled
    #1;
  endtask : do_reset
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so they are sampled there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, exp);
  endtask : rd
  // route: F flash, E external, Z zero fill, B blocked write
  task automatic do_fetch(input pmsd_pkg::pmsd_vec_t v, input pmsd_pkg::pmsd_kind_t k, input logic [20:0] a,
                          input logic [20:0] ea, input logic [1:0] er);
    logic [1:0]  r;
    logic [15:0] w;
    logic        seen;
    logic        done;
    int          i;
    r    = B;
    w    = 16'h0000;
    seen = 1'b0;
    done = 1'b0;
    @(posedge clk_sys_in);
    fetch_req_in <= 1'b1;
    fetch_in     <= {v, k, a};
    @(posedge clk_sys_in);
    fetch_req_in <= 1'b0;
    #1;
    chk(prog_addr_out, ea);
    chk(prog_we_out, k == TW && er < Z);
    for (i = 0; i < 12 && !done; i++) begin
      if (flash_req_out || ext_req_out) seen = 1'b1;
      if (flash_req_out) r = F;
      if (ext_req_out) r = E;
      if (!seen && prog_word_valid_out) r = Z;
      if (prog_word_valid_out) w = prog_word_out;
      done = prog_word_valid_out || blocked_out || (seen && k == TW);
      if (!done) @(posedge clk_sys_in);
      if (!done) #1;
    end
    if (!done) begin
      num_errors++;
      final_report();
    end
    chk(r, er);
    if (k != TW) chk(w, er == F ? ea[15:0] ^ 16'h5a5a : er == E ? ea[15:0] ^ 16'ha5a5 : 16'h0000);
  endtask : do_fetch
  task automatic f(input pmsd_pkg::pmsd_kind_t k, input logic [20:0] a, input logic [1:0] er);
    do_fetch(pmsd_pkg::vec_none, k, a, a, er);
  endtask : f
  // data strobe and program fetch launched on the same edge
  task automatic t_data(input logic we, input logic [11:0] da);
    @(posedge clk_sys_in);
    data_req_in  <= 1'b1;
    data_we_in   <= we;
    data_addr_in <= da;
    fetch_req_in <= 1'b1;
    fetch_in     <= {pmsd_pkg::vec_none, EX, 21'h000100};
    @(posedge clk_sys_in);
    data_req_in  <= 1'b0;
    fetch_req_in <= 1'b0;
    #1;
    chk(data_req_out, 1'b1);
    chk(data_we_out, we);
    chk(data_addr_out, da);
    chk(flash_req_out || ext_req_out, 1'b1);
    repeat (6) @(posedge clk_sys_in);
    $display("test data port done");
  endtask : t_data
  task automatic t_internal;
    do_reset(8'hff);
    chk(memory_map_select_out, 2'h3);
    rd(4'h0, 8'h83);
    chk(ext_wait_out, 2'h0);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h83);
    rd(4'h5, 8'h00);
    wr(4'h1, 8'h30);
    rd(4'h1, 8'h30);
    chk(ext_wait_out, 2'h0);
    f(EX, 21'h000100, F);
    f(EX, 21'h007fff, F);
    f(EX, 21'h008000, Z);
    f(TR, 21'h010000, Z);
    f(EX, 21'h1fffff, Z);
    f(TW, 21'h000040, F);
    f(TW, 21'h008000, B);
    rd(4'h2, 8'he3);
    wr(4'h2, 8'h80);
    rd(4'h2, 8'h63);
    do_fetch(pmsd_pkg::vec_reset, EX, 21'h012345, 21'h000000, F);
    do_fetch(pmsd_pkg::vec_high, EX, 21'h012345, 21'h000008, F);
    do_fetch(pmsd_pkg::vec_low, EX, 21'h012345, 21'h000018, F);
    t_data(1'b0, 12'h0a5);
    $display("test internal map done");
  endtask : t_internal
  task automatic t_external;
    do_reset(8'h02);
    chk(memory_map_select_out, 2'h2);
    chk(nb_map, 2'h3);
    f(EX, 21'h000000, E);
    f(TR, 21'h007fff, E);
    f(TW, 21'h000010, E);
    f(EX, 21'h1fffff, E);
    do_fetch(pmsd_pkg::vec_high, EX, 21'h000400, 21'h000008, E);
    wr(4'h1, 8'h20);
    @(posedge clk_sys_in);
    #1;
    chk(ext_wait_out, 2'h2);
    t_data(1'b1, 12'h5a3);
    $display("test external map done");
  endtask : t_external
  // slow partner here: the switch at the boot limit must not depend on latency
  task automatic t_boot;
    do_reset(8'h01);
    slow <= 1'b1;
    chk(memory_map_select_out, 2'h1);
    f(EX, 21'h0007ff, F);
    f(EX, 21'h000800, E);
    f(EX, 21'h0007fe, F);
    f(TR, 21'h010000, E);
    f(TW, 21'h000000, F);
    slow <= 1'b0;
    $display("test boot map done");
  endtask : t_boot
  task automatic t_extended;
    do_reset(8'h00);
    chk(memory_map_select_out, 2'h0);
    f(EX, 21'h007fff, F);
    f(EX, 21'h008000, E);
    f(TR, 21'h000000, F);
    f(EX, 21'h1fffff, E);
    @(posedge clk_sys_in);
    cfg_byte_in <= 8'hff;
    repeat (4) @(posedge clk_sys_in);
    f(EX, 21'h008000, E);
    chk(memory_map_select_out, 2'h0);
    $display("test extended map done");
  endtask : t_extended

  initial begin
    rst_in       <= 1'b1;
    cfg_byte_in  <= 8'hff;
    reg_wr_in    <= 1'b0;
    reg_rd_in    <= 1'b0;
    reg_addr_in  <= 4'h0;
    reg_wdata_in <= 8'h00;
    fetch_req_in <= 1'b0;
    fetch_in     <= '0;
    data_req_in  <= 1'b0;
    data_we_in   <= 1'b0;
    data_addr_in <= 12'h000;
    slow         <= 1'b0;
    t_internal();
    t_external();
    t_boot();
    t_extended();
    final_report();
  end
endmodule : program_memory_space_decoder_tb
`default_nettype wire
